// file: src/tct_defs.svh
`ifndef TCT_DEFS_SVH
`define TCT_DEFS_SVH

`define TCT_NUM 3
`define TCT_ADDR_W 8
`define TCT_DATA_W 32
`define TCT_CNT_W 32
`define TCT_PSC_W 16
`define TCT_SRC_N 3

// address map: addr[7:6] page, addr[5:4] timer index, addr[3:0] word offset
`define TCT_PAGE 2'h0
`define TCT_GLB_IDX 2'h3
`define TCT_OFS_PERIOD 4'h0
`define TCT_OFS_PRESCALE 4'h4
`define TCT_OFS_COUNT 4'h8
`define TCT_OFS_CTRL 4'hc
`define TCT_OFS_CLKSEL 4'h0
`define TCT_OFS_STATUS 4'h4
`define TCT_OFS_MASK 4'h8
`define TCT_OFS_ROUTE 4'hc

// field positions
`define TCT_CTRL_RUN 0
`define TCT_CTRL_RELOAD 1
`define TCT_ROUTE_LINE13 0
`define TCT_ST_ZERO 0
`define TCT_ST_OVR 4
`define TCT_ST_W 8
`define TCT_PSC_LIVE_LSB 16

// reset values
`define TCT_PERIOD_RST 32'hffff_ffff
`define TCT_PRESCALE_RST 16'h0000
`define TCT_RUN_RST 1'b0
`define TCT_ROUTE_RST 1'b0
`define TCT_MASK_RST 8'h00

`endif

// file: src/tct_pkg.sv
`include "tct_defs.svh"

package tct_pkg;

    typedef enum logic [1:0] {
        TCT_SRC_SYSCLK = 2'b00,
        TCT_SRC_OSC1 = 2'b01,
        TCT_SRC_OSC2 = 2'b10,
        TCT_SRC_EXT = 2'b11
    } tct_src_t;

    typedef struct packed {
        logic [`TCT_CNT_W-1:0] period;
        logic [`TCT_PSC_W-1:0] prescale;
        logic run;
    } tct_cfg_t;

    typedef struct packed {
        logic load;
        logic [`TCT_CNT_W-1:0] value;
        logic reload;
    } tct_cmd_t;

    typedef struct packed {
        logic [`TCT_CNT_W-1:0] count;
        logic [`TCT_PSC_W-1:0] psc_count;
    } tct_view_t;

    typedef struct packed {
        logic [`TCT_CNT_W-1:0] count;
        logic [`TCT_PSC_W-1:0] psc;
        logic zero;
    } tct_tmr_st_t;

    typedef struct packed {
        logic [`TCT_SRC_N-1:0] s1;
        logic [`TCT_SRC_N-1:0] s2;
        logic [`TCT_SRC_N-1:0] s3;
        logic [`TCT_SRC_N-1:0] lvl;
        logic tick;
    } tct_src_st_t;

    typedef struct packed {
        tct_cfg_t [`TCT_NUM-1:0] cfg;
        tct_src_t src;
        logic route13;
        logic [`TCT_ST_W-1:0] status;
        logic [`TCT_ST_W-1:0] mask;
        logic [`TCT_DATA_W-1:0] rdata;
    } tct_top_st_t;

endpackage

// file: src/tct_clk_src.sv
`timescale 1ns/1ps
`include "tct_defs.svh"

module tct_clk_src (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic internal_oscillator_one,
    input wire logic internal_oscillator_two,
    input wire logic external_clock,
    input wire tct_pkg::tct_src_t sel,
    output logic tick
);
    tct_pkg::tct_src_st_t st_reg;
    tct_pkg::tct_src_st_t st_next;
    logic [`TCT_SRC_N-1:0] raw;

    assign raw = {external_clock, internal_oscillator_two, internal_oscillator_one};

    // sources must toggle well below clk/4, otherwise edges are lost
    always_comb
    begin
        st_next = st_reg;
        st_next.s1 = raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.tick = 1'b0;
        for (int i = 0; i < `TCT_SRC_N; i++)
        begin
            if (st_reg.s2[i] == st_reg.s3[i])
            begin
                st_next.lvl[i] = st_reg.s3[i];
            end
        end
        case (sel)
            tct_pkg::TCT_SRC_OSC1: st_next.tick = st_next.lvl[0] & ~st_reg.lvl[0];
            tct_pkg::TCT_SRC_OSC2: st_next.tick = st_next.lvl[1] & ~st_reg.lvl[1];
            tct_pkg::TCT_SRC_EXT: st_next.tick = st_next.lvl[2] & ~st_reg.lvl[2];
            default: st_next.tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // system clock source counts every cycle
    assign tick = (sel == tct_pkg::TCT_SRC_SYSCLK) ? 1'b1 : st_reg.tick;
endmodule

// file: src/tct_timer.sv
`timescale 1ns/1ps
`include "tct_defs.svh"

module tct_timer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic count_en,
    input wire tct_pkg::tct_cfg_t cfg,
    input wire tct_pkg::tct_cmd_t cmd,
    output tct_pkg::tct_view_t view,
    output logic zero_evt
);
    tct_pkg::tct_tmr_st_t st_reg;
    tct_pkg::tct_tmr_st_t st_next;

    always_comb
    begin
        logic dec;
        dec = 1'b0;
        st_next = st_reg;
        st_next.zero = 1'b0;
        if (cmd.reload)
        begin
            st_next.count = cfg.period;
            st_next.psc = cfg.prescale;
        end
        else if (cmd.load)
        begin
            st_next.count = cmd.value;
        end
        else if (cfg.run && count_en)
        begin
            if (st_reg.psc == '0)
            begin
                st_next.psc = cfg.prescale;
                dec = 1'b1;
            end
            else
            begin
                st_next.psc = st_reg.psc - 1'b1;
            end
            if (dec)
            begin
                if (st_reg.count == '0)
                begin
                    st_next.count = cfg.period;
                end
                else
                begin
                    st_next.count = st_reg.count - 1'b1;
                end
                // a zero period sits at zero and fires on every prescaled decrement (every tick only when prescale is zero)
                if (st_reg.count == `TCT_CNT_W'(1) || (st_reg.count == '0 && cfg.period == '0))
                begin
                    st_next.zero = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg.count <= `TCT_PERIOD_RST;
            st_reg.psc <= `TCT_PRESCALE_RST;
            st_reg.zero <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // one driver for the whole view keeps the packed port single-sourced
    assign view = {st_reg.count, st_reg.psc};
    assign zero_evt = st_reg.zero;
endmodule

// file: src/tct_top.sv
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "tct_defs.svh"

module tct_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`TCT_ADDR_W-1:0] reg_addr,
    input wire logic [`TCT_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`TCT_DATA_W-1:0] reg_rdata,
    input wire logic internal_oscillator_one,
    input wire logic internal_oscillator_two,
    input wire logic external_clock,
    output logic peripheral_interrupt_expander_req,
    output logic cpu_interrupt_line_thirteen,
    output logic cpu_interrupt_line_fourteen
);
    tct_pkg::tct_top_st_t st_reg;
    tct_pkg::tct_top_st_t st_next;
    tct_pkg::tct_cmd_t [`TCT_NUM-1:0] cmd;
    tct_pkg::tct_view_t [`TCT_NUM-1:0] view;
    logic [`TCT_NUM-1:0] zero_evt;
    logic [`TCT_NUM-1:0] count_en;
    logic [`TCT_NUM-1:0] line;
    logic src_tick;
    logic page_hit;
    logic [1:0] t_idx;
    logic [3:0] ofs;

    assign page_hit = (reg_addr[7:6] == `TCT_PAGE);
    assign t_idx = reg_addr[5:4];
    assign ofs = reg_addr[3:0];

    tct_clk_src u_src (
        .clk(clk),
        .sys_rst(sys_rst),
        .internal_oscillator_one(internal_oscillator_one),
        .internal_oscillator_two(internal_oscillator_two),
        .external_clock(external_clock),
        .sel(st_reg.src),
        .tick(src_tick)
    );

    genvar g;
    generate
        for (g = 0; g < `TCT_NUM; g++)
        begin : g_tmr
            // only the last timer has a selectable source
            assign count_en[g] = (g == `TCT_NUM - 1) ? src_tick : 1'b1;
            tct_timer u_tmr (
                .clk(clk),
                .sys_rst(sys_rst),
                .count_en(count_en[g]),
                .cfg(st_reg.cfg[g]),
                .cmd(cmd[g]),
                .view(view[g]),
                .zero_evt(zero_evt[g])
            );
            assign line[g] = (st_reg.status[`TCT_ST_ZERO + g] & st_reg.mask[`TCT_ST_ZERO + g])
                | (st_reg.status[`TCT_ST_OVR + g] & st_reg.mask[`TCT_ST_OVR + g]);
        end
    endgenerate

    always_comb
    begin
        logic [`TCT_ST_W-1:0] set;
        logic [`TCT_ST_W-1:0] clr;
        set = '0;
        clr = '0;
        st_next = st_reg;
        st_next.rdata = '0;
        cmd = '0;
        if (reg_wr && page_hit)
        begin
            if (t_idx != `TCT_GLB_IDX)
            begin
                case (ofs)
                    `TCT_OFS_PERIOD: st_next.cfg[t_idx].period = reg_wdata;
                    `TCT_OFS_PRESCALE:
                        st_next.cfg[t_idx].prescale = reg_wdata[`TCT_PSC_W-1:0];
                    `TCT_OFS_COUNT:
                    begin
                        cmd[t_idx].load = 1'b1;
                        cmd[t_idx].value = reg_wdata;
                    end
                    `TCT_OFS_CTRL:
                    begin
                        st_next.cfg[t_idx].run = reg_wdata[`TCT_CTRL_RUN];
                        cmd[t_idx].reload = reg_wdata[`TCT_CTRL_RELOAD];
                    end
                    default: ;
                endcase
            end
            else
            begin
                case (ofs)
                    `TCT_OFS_CLKSEL: st_next.src = tct_pkg::tct_src_t'(reg_wdata[1:0]);
                    `TCT_OFS_STATUS: clr = reg_wdata[`TCT_ST_W-1:0];
                    `TCT_OFS_MASK: st_next.mask = reg_wdata[`TCT_ST_W-1:0];
                    `TCT_OFS_ROUTE: st_next.route13 = reg_wdata[`TCT_ROUTE_LINE13];
                    default: ;
                endcase
            end
        end
        if (reg_rd && page_hit)
        begin
            if (t_idx != `TCT_GLB_IDX)
            begin
                case (ofs)
                    `TCT_OFS_PERIOD: st_next.rdata = st_reg.cfg[t_idx].period;
                    `TCT_OFS_PRESCALE:
                    begin
                        st_next.rdata[`TCT_PSC_W-1:0] = st_reg.cfg[t_idx].prescale;
                        st_next.rdata[`TCT_PSC_LIVE_LSB +: `TCT_PSC_W] = view[t_idx].psc_count;
                    end
                    `TCT_OFS_COUNT: st_next.rdata = view[t_idx].count;
                    `TCT_OFS_CTRL: st_next.rdata[`TCT_CTRL_RUN] = st_reg.cfg[t_idx].run;
                    default: st_next.rdata = '0;
                endcase
            end
            else
            begin
                case (ofs)
                    `TCT_OFS_CLKSEL: st_next.rdata[1:0] = st_reg.src;
                    `TCT_OFS_STATUS: st_next.rdata[`TCT_ST_W-1:0] = st_reg.status;
                    `TCT_OFS_MASK: st_next.rdata[`TCT_ST_W-1:0] = st_reg.mask;
                    `TCT_OFS_ROUTE: st_next.rdata[`TCT_ROUTE_LINE13] = st_reg.route13;
                    default: st_next.rdata = '0;
                endcase
            end
        end
        // a second zero while the first is still pending is flagged as overrun
        for (int i = 0; i < `TCT_NUM; i++)
        begin
            set[`TCT_ST_ZERO + i] = zero_evt[i];
            set[`TCT_ST_OVR + i] = zero_evt[i] & st_reg.status[`TCT_ST_ZERO + i]
                & ~clr[`TCT_ST_ZERO + i];
        end
        // set wins over a clear in the same cycle
        st_next.status = (st_reg.status & ~clr) | set;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < `TCT_NUM; i++)
            begin
                st_reg.cfg[i].period <= `TCT_PERIOD_RST;
                st_reg.cfg[i].prescale <= `TCT_PRESCALE_RST;
                st_reg.cfg[i].run <= `TCT_RUN_RST;
            end
            st_reg.src <= tct_pkg::TCT_SRC_SYSCLK;
            st_reg.route13 <= `TCT_ROUTE_RST;
            st_reg.status <= '0;
            st_reg.mask <= `TCT_MASK_RST;
            st_reg.rdata <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign peripheral_interrupt_expander_req = line[0];
    assign cpu_interrupt_line_thirteen = line[1] & st_reg.route13;
    assign cpu_interrupt_line_fourteen = line[2];
endmodule

// file: dv/tct_far_model.sv
`timescale 1ns/1ps

// count sources for timer two; each toggles only while enabled and stands still otherwise
// limitation: phase-locked to clk, so the synchroniser sees no metastable edges
module tct_far_model (
    input wire logic clk,
    input wire logic [2:0] src_en,
    output logic [2:0] src_clk
);
    logic [7:0] cnt = 8'h00;
    logic [2:0] lvl = 3'h0;
    // wrap at a common multiple of 3, 4 and 5 so no source ever toggles on two adjacent edges
    always @(posedge clk)
    begin
        cnt <= (cnt == 8'h3b) ? 8'h00 : cnt + 8'h01;
        for (int i = 0; i < 3; i++)
            if (src_en[i] && cnt % (3 + i) == 0)
                lvl[i] <= ~lvl[i];
    end
    assign src_clk = lvl;
endmodule

// file: dv/tct_top_sva.sv
`timescale 1ns/1ps
`include "tct_defs.svh"

module tct_top_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`TCT_ADDR_W-1:0] reg_addr,
    input wire logic [`TCT_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`TCT_DATA_W-1:0] reg_rdata,
    input wire logic peripheral_interrupt_expander_req,
    input wire logic cpu_interrupt_line_thirteen,
    input wire logic cpu_interrupt_line_fourteen
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] period_reg [3];
    logic [7:0] mask_reg;
    logic route_reg;
    logic [1:0] sel_reg;
    wire glb_wr = reg_wr && reg_addr[7:4] == 4'h3;
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 3; i++)
            if (sys_rst)
                period_reg[i] <= 32'hffff_ffff;
            else if (reg_wr && reg_addr == {2'h0, i[1:0], 4'h0})
                period_reg[i] <= reg_wdata;
        if (sys_rst)
        begin
            mask_reg <= 8'h00;
            route_reg <= 1'b0;
            sel_reg <= 2'h0;
        end
        else if (glb_wr)
        begin
            if (reg_addr[3:0] == 4'h8)
                mask_reg <= reg_wdata[7:0] & 8'h77;
            if (reg_addr[3:0] == 4'hc)
                route_reg <= reg_wdata[0];
            if (reg_addr[3:0] == 4'h0)
                sel_reg <= reg_wdata[1:0];
        end
    end
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside a read slot");
    a_unmapped_zero: assert property ($past(reg_rd && reg_addr[7:6] != 2'h0)
        |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_period_read: assert property ($past(reg_rd && reg_addr[7:6] == 2'h0
        && reg_addr[5:4] != 2'h3 && reg_addr[3:0] == 4'h0)
        |-> reg_rdata == period_reg[$past(reg_addr[5:4])])
        else $error("period readback wrong");
    a_route_read: assert property ($past(reg_rd && reg_addr == 8'h3c)
        |-> reg_rdata == {31'h0, route_reg})
        else $error("route readback wrong");
    a_sel_read: assert property ($past(reg_rd && reg_addr == 8'h30)
        |-> reg_rdata == {30'h0, sel_reg})
        else $error("source select readback wrong");
    a_pie_masked: assert property (peripheral_interrupt_expander_req
        |-> mask_reg[0] || mask_reg[4])
        else $error("expander request while masked");
    a_line13_route: assert property (cpu_interrupt_line_thirteen
        |-> route_reg && (mask_reg[1] || mask_reg[5]))
        else $error("line thirteen without route or mask");
    a_line14_mask: assert property (cpu_interrupt_line_fourteen
        |-> mask_reg[2] || mask_reg[6])
        else $error("line fourteen while masked");
    a_irq_sticky: assert property ($past(peripheral_interrupt_expander_req)
        && !$past(reg_wr) |-> peripheral_interrupt_expander_req)
        else $error("expander request dropped without a write");
    c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
    c_pie: cover property ($rose(peripheral_interrupt_expander_req));
    c_line13: cover property ($rose(cpu_interrupt_line_thirteen));
    c_line14: cover property ($rose(cpu_interrupt_line_fourteen));
endmodule

bind tct_top tct_top_sva tct_top_sva_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .peripheral_interrupt_expander_req(peripheral_interrupt_expander_req),
    .cpu_interrupt_line_thirteen(cpu_interrupt_line_thirteen),
    .cpu_interrupt_line_fourteen(cpu_interrupt_line_fourteen));

// file: dv/tb.sv
`timescale 1ns/1ps
`include "tct_defs.svh"

module tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [2:0] src_en = 3'h0;
    logic [2:0] src_clk;
    logic pie_req, line13, line14;
    logic [31:0] d;
    int errors = 0;
    int cmp_count = 0;
    int seed = 32'ha331;
    always #5 clk = ~clk;
    tct_top tct_top_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .internal_oscillator_one(src_clk[0]), .internal_oscillator_two(src_clk[1]),
        .external_clock(src_clk[2]), .peripheral_interrupt_expander_req(pie_req),
        .cpu_interrupt_line_thirteen(line13), .cpu_interrupt_line_fourteen(line14));
    tct_far_model tct_far_model_i (.clk(clk), .src_en(src_en), .src_clk(src_clk));
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // an idle edge after each strobe keeps every strobe a single assignment per step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk);
    endtask
    function automatic logic [31:0] cnt_at(input logic [31:0] p, input logic [15:0] s,
        input int k);
        logic [31:0] c;
        logic [15:0] q;
        c = p;
        q = s;
        for (int i = 0; i < k; i++)
            if (q == 16'h0)
            begin
                q = s;
                c = (c == 32'h0) ? p : c - 32'h1;
            end
            else
                q = q - 16'h1;
        return c;
    endfunction
    initial
    begin
        #200us;
        errors++;
        conclude();
    end
    initial
    begin : main
        logic [31:0] p;
        logic [15:0] s;
        logic [7:0] b;
        int w;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int t = 0; t < 3; t++)
        begin
            b = {2'h0, t[1:0], 4'h0};
            rd(b, d);
            chk(d, 32'hffff_ffff);
            rd(b + 8'h4, d);
            chk({16'h0, d[15:0]}, 32'h0);
            rd(b + 8'h8, d);
            chk(d, 32'hffff_ffff);
            rd(8'h30 + {t[5:0], 2'h0}, d);
            chk(d, 32'h0);
        end
        rd(8'h3c, d);
        chk(d, 32'h0);
        rd(8'h44, d);
        chk(d, 32'h0);
        $display("test reset values done");
        for (int t = 0; t < 3; t++)
            for (int i = 0; i < 4; i++)
            begin
                b = {2'h0, t[1:0], 4'h0};
                p = (i == 0) ? 32'h1 : 32'h2 + ($random(seed) & 32'h7);
                s = (i == 0) ? 16'h0 : 16'($random(seed) & 3);
                w = (i == 0) ? 2 : $random(seed) & 31;
                wr(b, p);
                wr(b + 8'h4, {16'h0, s});
                wr(b + 8'hc, 32'h3);
                repeat (w) @(posedge clk);
                rd(b + 8'h8, d);
                chk(d, cnt_at(p, s, w + 1));
            end
        $display("test countdown done");
        wr(8'h38, 32'h77);
        repeat (40) @(posedge clk);
        #1 chk({29'h0, pie_req, line13, line14}, 32'h5);
        wr(8'h3c, 32'h1);
        #1 chk({31'h0, line13}, 32'h1);
        for (int t = 0; t < 3; t++)
            wr({2'h0, t[1:0], 4'hc}, 32'h0);
        wr(8'h34, 32'h77);
        rd(8'h34, d);
        chk(d, 32'h0);
        #1 chk({29'h0, pie_req, line13, line14}, 32'h0);
        wr(8'h38, 32'h0);
        wr(8'h0c, 32'h3);
        repeat (40) @(posedge clk);
        rd(8'h34, d);
        chk(d & 32'h1, 32'h1);
        #1 chk({31'h0, pie_req}, 32'h0);
        wr(8'h38, 32'h1);
        #1 chk({31'h0, pie_req}, 32'h1);
        $display("test interrupts done");
        for (int k = 1; k < 4; k++)
        begin
            wr(8'h2c, 32'h0);
            wr(8'h30, k);
            wr(8'h20, 32'h100);
            wr(8'h24, 32'h0);
            src_en <= ~(3'h1 << (k - 1));
            wr(8'h2c, 32'h3);
            repeat (40) @(posedge clk);
            rd(8'h28, d);
            chk(d, 32'h100);
            src_en <= 3'h1 << (k - 1);
            repeat (60) @(posedge clk);
            rd(8'h28, d);
            chk({31'h0, d < 32'h100 && d > 32'he0}, 32'h1);
            src_en <= 3'h0;
        end
        $display("test count sources done");
        wr(8'h18, 32'h1234_5678);
        rd(8'h18, d);
        chk(d, 32'h1234_5678);
        rd(8'h1c, d);
        chk(d, 32'h0);
        // two reset edges so the irq outputs are already low when the checker resumes
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(8'h08, d);
        chk(d, 32'hffff_ffff);
        #1 chk({29'h0, pie_req, line13, line14}, 32'h0);
        $display("test load and reset done");
        conclude();
    end
endmodule
